// ===== rtl/tms_clk_modulator.sv
// on-demand duty-cycle gate for the core clock
// assumes the clock stop logic honours clkRun one phase at a time
`timescale 1ns/100ps
`default_nettype none
module tms_clk_modulator #(
  parameter int unsigned DIV = 1
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       modEnable,
  input  wire logic [3:0] dutyCode,
  output logic            clkRun
);
  import tms_pkg::*;
  logic [7:0] divCnt_reg;
  logic [7:0] divCnt_next;
  logic [3:0] phase_reg;
  logic [3:0] phase_next;
  logic       clkRun_reg;
  logic       clkRun_next;
  logic       step;

  // phase advance on a divided enable, run for dutyCode of 16 phases, all 16 when dutyCode is 0
  always_comb begin
    step = (divCnt_reg == 8'(DIV - 1));
    divCnt_next = step ? 8'h00 : divCnt_reg + 8'h01;
    phase_next = step ? phase_reg + 4'h1 : phase_reg;
    clkRun_next = !modEnable || dutyCode == 4'h0 || phase_reg < dutyCode;
  end

  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_reg <= 8'h00;
      phase_reg  <= 4'h0;
      clkRun_reg <= 1'b1;
    end else begin
      divCnt_reg <= divCnt_next;
      phase_reg  <= phase_next;
      clkRun_reg <= clkRun_next;
    end
  end

  assign clkRun = clkRun_reg;

  mod_off_run_a: assert property (@(posedge sys_clk) disable iff (!nrst) !modEnable |=> clkRun)
    else $error("clock gated while modulation off");
  mod_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    modEnable && dutyCode != 4'h0 && phase_reg >= dutyCode |=> !clkRun)
    else $error("clock ran outside duty window");
endmodule
`default_nettype wire

// ===== rtl/tms_pkg.sv
// thermal management register block: shared constants
// assumes model-specific register numbers arrive as 12-bit addresses
package tms_pkg;
  localparam int MSR_AW = 12;
  // register numbers
  localparam logic [11:0] ADDR_CLK_MOD  = 12'h19a;
  localparam logic [11:0] ADDR_CORE_IRQ = 12'h19b;
  localparam logic [11:0] ADDR_CORE_ST  = 12'h19c;
  localparam logic [11:0] ADDR_MISC     = 12'h1a0;
  localparam logic [11:0] ADDR_EPB      = 12'h1b0;
  localparam logic [11:0] ADDR_PKG_ST   = 12'h1b1;
  localparam logic [11:0] ADDR_PKG_IRQ  = 12'h1b2;
  // clock modulation fields
  localparam int MOD_EXT_BIT  = 0;
  localparam int MOD_DUTY_LSB = 1;
  localparam int MOD_EN_BIT   = 4;
  localparam int MOD_W        = 5;
  // interrupt control fields
  localparam int IRQ_HI_BIT   = 0;
  localparam int IRQ_LO_BIT   = 1;
  localparam int IRQ_HOT_BIT  = 2;
  localparam int IRQ_FRC_BIT  = 3;
  localparam int IRQ_CRIT_BIT = 4;
  localparam int THR1_LSB     = 8;
  localparam int THR1_EN_BIT  = 15;
  localparam int THR2_LSB     = 16;
  localparam int THR2_EN_BIT  = 23;
  localparam int PWR_EN_BIT   = 24;
  localparam int IRQ_W        = 25;
  localparam int THR_W        = 7;
  localparam logic [24:0] CORE_IRQ_MASK = 25'h1ffff1f;
  localparam logic [24:0] PKG_IRQ_MASK  = 25'h1ffff17;
  // status fields
  localparam int TEMP_LSB  = 16;
  localparam int RES_LSB   = 27;
  localparam int VALID_BIT = 31;
  localparam int N_CORE    = 8;
  localparam int N_PKG     = 6;
  // live condition index within a status group
  localparam int LV_THERM = 0;
  localparam int LV_PROC  = 1;
  localparam int LV_CRIT  = 2;
  localparam int LV_THR1  = 3;
  localparam int LV_THR2  = 4;
  localparam int LV_PWR   = 5;
  localparam int LV_CUR   = 6;
  localparam int LV_XDOM  = 7;
  // misc enable and bias hint
  localparam int MISC_AUTO_BIT = 3;
  localparam int EPB_W         = 4;
  // reset values
  localparam logic [4:0]  CLK_MOD_RST   = 5'h00;
  localparam logic [24:0] IRQ_RST       = 25'h0000000;
  localparam logic        MISC_AUTO_RST = 1'b0;
  localparam logic [3:0]  EPB_RST       = 4'h0;
  // modulation phases per period
  localparam int MOD_PHASES = 16;
endpackage

// ===== rtl/tms_status_log.sv
// sticky log bits beside live status conditions
// assumes live inputs are already in the sys_clk domain
`timescale 1ns/100ps
`default_nettype none
module tms_status_log #(
  parameter int         N       = 8,
  parameter logic [7:0] RW_MASK = 8'h01
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [N-1:0] live,
  input  wire logic         wrEn,
  input  wire logic [N-1:0] wrData,
  output logic      [N-1:0] logs,
  output logic      [N-1:0] rise
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] logs_reg;
  logic [N-1:0] logs_next;

  // write zero clears, plain r/w where masked, hardware set wins
  always_comb begin
    rise = live & ~prev_reg;
    logs_next = logs_reg;
    if (wrEn) begin
      logs_next = (logs_reg & wrData & ~RW_MASK[N-1:0]) | (wrData & RW_MASK[N-1:0]);
    end
    logs_next = logs_next | rise;
  end

  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '0;
      logs_reg <= '0;
    end else begin
      prev_reg <= live;
      logs_reg <= logs_next;
    end
  end

  assign logs = logs_reg;

  default clocking cbl @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  set_wins_a: assert property (|rise |=> (logs & $past(rise)) == $past(rise))
    else $error("log bit missed its event");
  no_set_by_one_a: assert property (wrEn && rise == '0 |=> ((logs & ~$past(logs)) & ~RW_MASK[N-1:0]) == '0)
    else $error("write of one set a log bit");
endmodule
`default_nettype wire

// ===== rtl/tms_thermal_regs.sv
// thermal and power management register bank, reached by msr reads and writes
// assumes one request per cycle at most; sensor pins are asynchronous
//
// Overview of operation
// - modulation runs only while clock modulation enable bit 4 is one
// - bits 3:1 pick duty; bit 0 extends encoding when capability present
// - core irq enables: high 0, low 1, hot pin 2, forced 3, critical 4
// - thresholds: value 14:8 enable 15, value 22:16 enable 23
// - bit 24 power limit notify enable, only with power-limit capability
// - core live status read-only at bits 0, 2, 4, 6, 8
// - each live bit has log at next odd bit, cleared only by zero
// - thermal status log bit 1 is plain read/write
// - power 10, current 12, cross-domain 14 live, gated by capability
// - readout 22:16, resolution 30:27, valid 31, all read-only
// - misc bit 3 enables automatic thermal control, reset disabled
// - clear of that enable may be ignored while critical
// - bias hint 3:0, 0 performance, 15 energy saving
// - package status mirrors core bits 0..11, readout at 22:16
// - package irq enables 0,1,2,4 and 24; bit 3 reserved
// - package thresholds 14:8 and 22:16, enables 15 and 23
`timescale 1ns/100ps
`default_nettype none
module tms_thermal_regs #(
  parameter logic       CAP_EXT_DUTY  = 1'b1,
  parameter logic       CAP_PWR_LIMIT = 1'b1,
  parameter logic       CAP_CUR_LIMIT = 1'b1,
  parameter logic       CAP_CRIT_LOCK = 1'b1,
  parameter logic [3:0] TEMP_RES      = 4'h1,
  parameter int unsigned MOD_DIV      = 1
) (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic                        msrRdReq,
  input  wire logic                        msrWrReq,
  input  wire logic [tms_pkg::MSR_AW-1:0]  msrAddr,
  input  wire logic [63:0]                 msrWrData,
  output logic      [63:0]                 msrRdData,
  output logic                             msrAck,
  output logic                             msrFault,
  input  wire logic                        coreThermPin,
  input  wire logic                        coreHotPin,
  input  wire logic                        coreForcedThrottlePin,
  input  wire logic                        coreCritPin,
  input  wire logic                        corePwrLimPin,
  input  wire logic                        coreCurLimPin,
  input  wire logic                        coreXdomLimPin,
  input  wire logic [6:0]                  coreTempCode,
  input  wire logic                        coreTempValid,
  input  wire logic                        pkgThermPin,
  input  wire logic                        pkgHotPin,
  input  wire logic                        pkgCritPin,
  input  wire logic                        pkgPwrLimPin,
  input  wire logic [6:0]                  pkgTempCode,
  output logic                             coreThermIrq,
  output logic                             pkgThermIrq,
  output logic                             coreClkRun,
  output logic                             autoThermCtrlEn,
  output logic      [3:0]                  energyPerfHint
);
  import tms_pkg::*;

  localparam int SYNC_W = 26;
  localparam logic [4:0]  MOD_WMASK = {4'hf, CAP_EXT_DUTY};
  localparam logic [24:0] CORE_WMASK = {CAP_PWR_LIMIT, CORE_IRQ_MASK[23:0]};
  localparam logic [24:0] PKG_WMASK = {CAP_PWR_LIMIT, PKG_IRQ_MASK[23:0]};

  // status fields interleave live and log, bit 2k live, 2k+1 log
  function automatic logic [15:0] interleave(input logic [7:0] lv, input logic [7:0] lg);
    logic [15:0] r;
    r = 16'h0000;
    for (int k = 0; k < 8; k++) begin
      r[2*k] = lv[k];
      r[2*k+1] = lg[k];
    end
    return r;
  endfunction

  // log bits of a written status word
  function automatic logic [7:0] pickLogs(input logic [63:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      r[k] = d[2*k+1];
    end
    return r;
  endfunction

  logic [SYNC_W-1:0] syncA_reg;
  logic [SYNC_W-1:0] syncB_reg;
  logic [1:0]        syncFill_reg;
  logic [3:0]        prev_reg;
  logic [MOD_W-1:0]  modCtrl_reg;
  logic [MOD_W-1:0]  modCtrl_next;
  logic [IRQ_W-1:0]  coreIrqCtl_reg;
  logic [IRQ_W-1:0]  coreIrqCtl_next;
  logic [IRQ_W-1:0]  pkgIrqCtl_reg;
  logic [IRQ_W-1:0]  pkgIrqCtl_next;
  logic              autoTherm_reg;
  logic              autoTherm_next;
  logic [3:0]        epb_reg;
  logic [3:0]        epb_next;
  logic [63:0]       rdData_reg;
  logic [63:0]       rdData_next;
  logic              ack_reg;
  logic              fault_reg;
  logic              fault_next;
  logic              coreIrq_reg;
  logic              coreIrq_next;
  logic              pkgIrq_reg;
  logic              pkgIrq_next;
  logic [6:0]        coreTemp;
  logic [6:0]        pkgTemp;
  logic              coreValid;
  logic [N_CORE-1:0] coreLive;
  logic [N_CORE-1:0] coreLogs;
  logic [N_CORE-1:0] coreRise;
  logic [N_PKG-1:0]  pkgLive;
  logic [N_PKG-1:0]  pkgLogs;
  logic [N_PKG-1:0]  pkgRise;
  logic [7:0]        coreEvt;
  logic [6:0]        pkgEvt;
  logic              coreStWr;
  logic              pkgStWr;
  logic              hit;
  logic [3:0]        duty;
  logic [7:0]        wrLogs;
  logic [15:0]       pkgSt;

  // two-flop synchroniser for every sensor pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      prev_reg  <= 4'h0;
      syncFill_reg <= 2'b00;
    end else begin
      syncA_reg <= {pkgTempCode, pkgPwrLimPin, pkgCritPin, pkgHotPin, pkgThermPin, coreTempValid,
                    coreTempCode, coreXdomLimPin, coreCurLimPin, corePwrLimPin, coreCritPin,
                    coreForcedThrottlePin, coreHotPin, coreThermPin};
      syncB_reg <= syncA_reg;
      syncFill_reg <= {syncFill_reg[0], 1'b1}; // readout real two edges after reset
      prev_reg  <= {syncB_reg[15], syncB_reg[2], syncB_reg[1], syncB_reg[0]};
    end
  end

  // live conditions, thresholds compared against the readout
  always_comb begin
    coreTemp = syncB_reg[13:7];
    coreValid = syncB_reg[14];
    pkgTemp = syncB_reg[25:19];
    coreLive[LV_THERM] = syncB_reg[0];
    coreLive[LV_PROC] = syncB_reg[1] | syncB_reg[2];
    coreLive[LV_CRIT] = syncB_reg[3];
    coreLive[LV_THR1] = coreValid && coreTemp <= coreIrqCtl_reg[THR1_LSB +: THR_W];
    coreLive[LV_THR2] = coreValid && coreTemp <= coreIrqCtl_reg[THR2_LSB +: THR_W];
    coreLive[LV_PWR] = syncB_reg[4] & CAP_PWR_LIMIT;
    coreLive[LV_CUR] = syncB_reg[5] & CAP_CUR_LIMIT;
    coreLive[LV_XDOM] = syncB_reg[6] & CAP_CUR_LIMIT;
    pkgLive[LV_THERM] = syncB_reg[15];
    pkgLive[LV_PROC] = syncB_reg[16];
    pkgLive[LV_CRIT] = syncB_reg[17];
    pkgLive[LV_THR1] = syncFill_reg[1] && pkgTemp <= pkgIrqCtl_reg[THR1_LSB +: THR_W];
    pkgLive[LV_THR2] = syncFill_reg[1] && pkgTemp <= pkgIrqCtl_reg[THR2_LSB +: THR_W]; // no false crossing at reset
    pkgLive[LV_PWR] = syncB_reg[18] & CAP_PWR_LIMIT;
    coreStWr = msrWrReq && msrAddr == ADDR_CORE_ST;
    pkgStWr = msrWrReq && msrAddr == ADDR_PKG_ST;
    wrLogs = pickLogs(msrWrData);
    pkgSt = interleave({2'b00, pkgLive}, {2'b00, pkgLogs});
  end

  // core and package sticky logs
  tms_status_log #(.N(N_CORE), .RW_MASK(8'h01)) coreLogU (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .live    (coreLive),
    .wrEn    (coreStWr),
    .wrData  (wrLogs),
    .logs    (coreLogs),
    .rise    (coreRise)
  );

  tms_status_log #(.N(N_PKG), .RW_MASK(8'h01)) pkgLogU (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .live    (pkgLive),
    .wrEn    (pkgStWr),
    .wrData  (wrLogs[N_PKG-1:0]),
    .logs    (pkgLogs),
    .rise    (pkgRise)
  );

  // register writes and read mux
  always_comb begin
    modCtrl_next = modCtrl_reg;
    coreIrqCtl_next = coreIrqCtl_reg;
    pkgIrqCtl_next = pkgIrqCtl_reg;
    autoTherm_next = autoTherm_reg;
    epb_next = epb_reg;
    rdData_next = 64'h0;
    hit = 1'b1;
    case (msrAddr)
      ADDR_CLK_MOD: begin
        rdData_next = {59'h0, modCtrl_reg};
        if (msrWrReq) begin
          modCtrl_next = msrWrData[MOD_W-1:0] & MOD_WMASK;
        end
      end
      ADDR_CORE_IRQ: begin
        rdData_next = {39'h0, coreIrqCtl_reg};
        if (msrWrReq) begin
          coreIrqCtl_next = msrWrData[IRQ_W-1:0] & CORE_WMASK;
        end
      end
      ADDR_CORE_ST: begin
        rdData_next = {32'h0, coreValid, TEMP_RES, 4'h0, coreTemp, interleave(coreLive, coreLogs)};
      end
      ADDR_MISC: begin
        rdData_next = {60'h0, autoTherm_reg, 3'h0};
        if (msrWrReq) begin
          autoTherm_next = msrWrData[MISC_AUTO_BIT]
                         | (autoTherm_reg & coreLive[LV_CRIT] & CAP_CRIT_LOCK);
        end
      end
      ADDR_EPB: begin
        rdData_next = {60'h0, epb_reg};
        if (msrWrReq) begin
          epb_next = msrWrData[EPB_W-1:0];
        end
      end
      ADDR_PKG_ST: begin
        rdData_next = {41'h0, pkgTemp, 4'h0, pkgSt[11:0]};
      end
      ADDR_PKG_IRQ: begin
        rdData_next = {39'h0, pkgIrqCtl_reg};
        if (msrWrReq) begin
          pkgIrqCtl_next = msrWrData[IRQ_W-1:0] & PKG_WMASK;
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!msrRdReq) begin
      rdData_next = 64'h0;
    end
    fault_next = (msrRdReq || msrWrReq) && !hit;
  end

  // thermal events gated by their enables
  always_comb begin
    coreEvt = {coreRise[LV_PWR], coreRise[LV_THR2], coreRise[LV_THR1], coreRise[LV_CRIT],
               syncB_reg[2] & ~prev_reg[2], syncB_reg[1] & ~prev_reg[1],
               ~syncB_reg[0] & prev_reg[0], coreRise[LV_THERM]};
    pkgEvt = {pkgRise[LV_PWR], pkgRise[LV_THR2], pkgRise[LV_THR1], pkgRise[LV_CRIT],
              pkgRise[LV_PROC], ~syncB_reg[15] & prev_reg[3], pkgRise[LV_THERM]};
    coreIrq_next = |(coreEvt & {coreIrqCtl_reg[PWR_EN_BIT], coreIrqCtl_reg[THR2_EN_BIT],
                                coreIrqCtl_reg[THR1_EN_BIT], coreIrqCtl_reg[IRQ_CRIT_BIT:IRQ_HI_BIT]});
    pkgIrq_next = |(pkgEvt & {pkgIrqCtl_reg[PWR_EN_BIT], pkgIrqCtl_reg[THR2_EN_BIT],
                              pkgIrqCtl_reg[THR1_EN_BIT], pkgIrqCtl_reg[IRQ_CRIT_BIT],
                              pkgIrqCtl_reg[IRQ_HOT_BIT:IRQ_HI_BIT]});
    duty = {modCtrl_reg[MOD_EN_BIT-1:MOD_DUTY_LSB], modCtrl_reg[MOD_EXT_BIT]};
  end

  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      modCtrl_reg    <= CLK_MOD_RST;
      coreIrqCtl_reg <= IRQ_RST;
      pkgIrqCtl_reg  <= IRQ_RST;
      autoTherm_reg  <= MISC_AUTO_RST;
      epb_reg        <= EPB_RST;
      rdData_reg     <= 64'h0;
      ack_reg        <= 1'b0;
      fault_reg      <= 1'b0;
      coreIrq_reg    <= 1'b0;
      pkgIrq_reg     <= 1'b0;
    end else begin
      modCtrl_reg    <= modCtrl_next;
      coreIrqCtl_reg <= coreIrqCtl_next;
      pkgIrqCtl_reg  <= pkgIrqCtl_next;
      autoTherm_reg  <= autoTherm_next;
      epb_reg        <= epb_next;
      rdData_reg     <= rdData_next;
      ack_reg        <= msrRdReq | msrWrReq;
      fault_reg      <= fault_next;
      coreIrq_reg    <= coreIrq_next;
      pkgIrq_reg     <= pkgIrq_next;
    end
  end

  // duty-cycle gate
  tms_clk_modulator #(.DIV(MOD_DIV)) modU (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .modEnable (modCtrl_reg[MOD_EN_BIT]),
    .dutyCode  (duty),
    .clkRun    (coreClkRun)
  );

  assign msrRdData = rdData_reg;
  assign msrAck = ack_reg;
  assign msrFault = fault_reg;
  assign coreThermIrq = coreIrq_reg;
  assign pkgThermIrq = pkgIrq_reg;
  assign autoThermCtrlEn = autoTherm_reg;
  assign energyPerfHint = epb_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  reserved_zero_a: assert property (msrAck |-> msrRdData[63:32] == 32'h0)
    else $error("reserved bits read nonzero");
  auto_set_a: assert property (msrWrReq && msrAddr == ADDR_MISC && msrWrData[MISC_AUTO_BIT] |=> autoThermCtrlEn)
    else $error("auto thermal enable not set");
  crit_lock_a: assert property (msrWrReq && msrAddr == ADDR_MISC && !msrWrData[MISC_AUTO_BIT] && autoThermCtrlEn && coreLive[LV_CRIT]
                                |=> autoThermCtrlEn == CAP_CRIT_LOCK)
    else $error("critical lock not honoured");
  epb_write_a: assert property (msrWrReq && msrAddr == ADDR_EPB |=> energyPerfHint == $past(msrWrData[3:0]))
    else $error("bias hint not stored");
  irq_cause_a: assert property ($rose(coreThermIrq) |-> $past(|(coreEvt & {coreIrqCtl_reg[24], coreIrqCtl_reg[23],
                                coreIrqCtl_reg[15], coreIrqCtl_reg[4:0]})))
    else $error("core irq without enabled event");
  readout_a: assert property (msrRdReq && msrAddr == ADDR_CORE_ST ##1 $stable(coreTemp)
                              |-> msrRdData[22:16] == coreTemp && msrRdData[30:27] == TEMP_RES)
    else $error("readout field wrong");
  irq_rsvd_a: assert property (msrWrReq && msrAddr == ADDR_PKG_IRQ |=> pkgIrqCtl_reg[3] == 1'b0)
    else $error("package reserved bit stored");
  ack_fault_a: assert property ((msrRdReq || msrWrReq) |=> msrAck ##1 !msrFault || $past(msrRdReq || msrWrReq))
    else $error("request not answered");

  irq_seen_c: cover property (coreThermIrq);
  pkg_irq_c: cover property (pkgThermIrq);
  crit_hold_c: cover property (msrWrReq && msrAddr == ADDR_MISC && !msrWrData[3] && autoThermCtrlEn && coreLive[LV_CRIT]);
  gated_c: cover property (!coreClkRun);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// testbench for the thermal register bank: msr accesses, sensor pins, modulation
// assumes the bank answers each request one cycle later, default parameters
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tms_pkg::*;
  localparam logic [63:0] BASE = 64'h0000_0000_0800_0000; // resolution field alone
  localparam logic [63:0] PBASE = 64'h0000_0000_007f_0000; // package readout at 7f
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        rdReq = 1'b0;
  logic        wrReq = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [63:0] wrData = 64'h0;
  logic [63:0] rdData;
  logic        ack;
  logic        fault;
  logic [6:0]  corePins = 7'h00;
  logic [3:0]  pkgPins = 4'h0;
  logic [6:0]  coreTemp = 7'h00;
  logic        tempValid = 1'b0;
  logic        coreIrq;
  logic        pkgIrq;
  logic        clkRun;
  logic        autoEn;
  logic [3:0]  hint;
  int          err_count = 0;
  int          tests_run = 0;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  tms_thermal_regs uut (.sys_clk(sys_clk), .nrst(nrst), .msrRdReq(rdReq), .msrWrReq(wrReq), .msrAddr(addr),
    .msrWrData(wrData), .msrRdData(rdData), .msrAck(ack), .msrFault(fault), .coreThermPin(corePins[0]),
    .coreHotPin(corePins[1]), .coreForcedThrottlePin(corePins[2]), .coreCritPin(corePins[3]),
    .corePwrLimPin(corePins[4]), .coreCurLimPin(corePins[5]), .coreXdomLimPin(corePins[6]),
    .coreTempCode(coreTemp), .coreTempValid(tempValid), .pkgThermPin(pkgPins[0]), .pkgHotPin(pkgPins[1]),
    .pkgCritPin(pkgPins[2]), .pkgPwrLimPin(pkgPins[3]), .pkgTempCode(7'h7f), .coreThermIrq(coreIrq),
    .pkgThermIrq(pkgIrq), .coreClkRun(clkRun), .autoThermCtrlEn(autoEn), .energyPerfHint(hint));

  // verdict and end of run
  task automatic test_done;
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // the one comparison
  task automatic check64(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access, request held for one edge, answer taken after it
  task automatic msr(input logic w, input logic [11:0] a, input logic [63:0] d, input logic ef,
                     output logic [63:0] q);
    @(posedge sys_clk);
    rdReq <= ~w;
    wrReq <= w;
    addr <= a;
    wrData <= d;
    @(posedge sys_clk);
    rdReq <= 1'b0;
    wrReq <= 1'b0;
    #1;
    check64({63'h0, ack}, 64'h1);
    check64({63'h0, fault}, {63'h0, ef});
    q = rdData;
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    logic [63:0] q;
    msr(1'b1, a, d, 1'b0, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    logic [63:0] q;
    msr(1'b0, a, 64'h0, 1'b0, q);
    check64(q, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // bounded watch for an interrupt pulse
  task automatic watch(input bit pkg, output bit seen);
    seen = 0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      if ((pkg ? pkgIrq : coreIrq) === 1'b1) seen = 1;
    end
  endtask

  task automatic t_reset;
    rd(ADDR_CLK_MOD, 64'h0);
    rd(ADDR_CORE_IRQ, 64'h0);
    rd(ADDR_CORE_ST, BASE);
    rd(ADDR_MISC, 64'h0);
    rd(ADDR_EPB, 64'h0);
    rd(ADDR_PKG_ST, PBASE);
    rd(ADDR_PKG_IRQ, 64'h0);
    check64({63'h0, clkRun}, 64'h1);
  endtask

  // package events, masked then enabled
  task automatic t_pkg;
    int en[4] = '{0, 2, 4, 24};
    int st[4] = '{0, 2, 4, 10};
    bit seen;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        wr(ADDR_PKG_IRQ, p ? (64'h1 << en[k]) : 64'h0);
        @(posedge sys_clk);
        pkgPins[k] <= 1'b1;
        watch(1'b1, seen);
        check64({63'h0, seen}, p);
        rd(ADDR_PKG_ST, PBASE | (64'h3 << st[k]));
        pkgPins[k] <= 1'b0;
        idle(4);
        wr(ADDR_PKG_ST, 64'h0);
        rd(ADDR_PKG_ST, PBASE);
      end
    end
    wr(ADDR_PKG_IRQ, 64'h0);
  endtask

  task automatic t_status;
    wr(ADDR_CORE_ST, '1);
    rd(ADDR_CORE_ST, BASE | 64'h2);
    wr(ADDR_CORE_ST, 64'h0);
    rd(ADDR_CORE_ST, BASE);
  endtask

  task automatic t_readout;
    @(posedge sys_clk);
    coreTemp <= 7'h2a;
    tempValid <= 1'b1;
    idle(4);
    rd(ADDR_CORE_ST, BASE | 64'h8000_0000 | (64'h2a << 16));
    tempValid <= 1'b0;
    coreTemp <= 7'h00;
    idle(4);
  endtask

  // each core pin sets live and log, raises its enabled interrupt
  task automatic t_core_events;
    int en[7] = '{0, 2, 3, 4, 24, -1, -1};
    int st[7] = '{0, 2, 2, 4, 10, 12, 14};
    bit seen;
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_CORE_IRQ, (en[k] >= 0) ? (64'h1 << en[k]) : 64'h0);
      @(posedge sys_clk);
      corePins[k] <= 1'b1;
      watch(1'b0, seen);
      check64({63'h0, seen}, {63'h0, en[k] >= 0});
      rd(ADDR_CORE_ST, BASE | (64'h3 << st[k]));
      wr(ADDR_CORE_ST, 64'h0);
      rd(ADDR_CORE_ST, BASE | (64'h1 << st[k]));
      corePins[k] <= 1'b0;
      idle(4);
      wr(ADDR_CORE_ST, 64'h0);
    end
    wr(ADDR_CORE_IRQ, 64'h0);
  endtask

  // core threshold crossing, then a low-temperature transition, then a package threshold crossing
  task automatic t_thresh;
    bit seen;
    @(posedge sys_clk);
    coreTemp <= 7'h2a;
    tempValid <= 1'b1;
    idle(4);
    wr(ADDR_CORE_IRQ, 64'h0000_b000);
    watch(1'b0, seen);
    check64({63'h0, seen}, 64'h1);
    rd(ADDR_CORE_ST, BASE | 64'h802a_00c0);
    wr(ADDR_CORE_IRQ, 64'h2);
    corePins[0] <= 1'b1;
    idle(4);
    corePins[0] <= 1'b0;
    watch(1'b0, seen);
    check64({63'h0, seen}, 64'h1);
    wr(ADDR_PKG_IRQ, 64'h0000_ff00);
    watch(1'b1, seen);
    check64({63'h0, seen}, 64'h1);
    rd(ADDR_PKG_ST, PBASE | 64'hc0);
    wr(ADDR_PKG_IRQ, 64'h0);
    wr(ADDR_CORE_IRQ, 64'h0);
    tempValid <= 1'b0;
    coreTemp <= 7'h00;
    idle(4);
    wr(ADDR_PKG_ST, 64'h0);
    wr(ADDR_CORE_ST, 64'h0);
    rd(ADDR_CORE_ST, BASE);
  endtask

  task automatic t_crit_lock;
    wr(ADDR_MISC, 64'h8);
    check64({63'h0, autoEn}, 64'h1);
    corePins[3] <= 1'b1;
    idle(4);
    wr(ADDR_MISC, 64'h0);
    check64({63'h0, autoEn}, 64'h1);
    rd(ADDR_MISC, 64'h8);
    corePins[3] <= 1'b0;
    idle(4);
    wr(ADDR_MISC, 64'h0);
    check64({63'h0, autoEn}, 64'h0);
    wr(ADDR_CORE_ST, 64'h0);
  endtask

  // all ones written, only defined fields kept
  task automatic t_regs;
    logic [11:0] a[5] = '{ADDR_CLK_MOD, ADDR_CORE_IRQ, ADDR_MISC, ADDR_EPB, ADDR_PKG_IRQ};
    logic [63:0] m[5] = '{64'h1f, {39'h0, CORE_IRQ_MASK}, 64'h8, 64'hf, {39'h0, PKG_IRQ_MASK}};
    for (int k = 0; k < 5; k++) begin
      wr(a[k], '1);
      rd(a[k], m[k]);
      wr(a[k], 64'h0);
      rd(a[k], 64'h0);
    end
    wr(ADDR_EPB, 64'h5);
    check64({60'h0, hint}, 64'h5);
    wr(ADDR_EPB, 64'h0);
  endtask

  task automatic t_unmapped;
    logic [63:0] q;
    msr(1'b1, 12'h1b3, '1, 1'b1, q);
    msr(1'b0, 12'h19d, 64'h0, 1'b1, q);
    check64(q, 64'h0);
    rd(ADDR_EPB, 64'h0);
  endtask

  // low phases counted over two full periods
  task automatic t_modulation;
    logic [63:0] d[5] = '{64'h12, 64'h13, 64'h1f, 64'h10, 64'h02};
    int exp[5] = '{28, 26, 2, 0, 0};
    int n;
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CLK_MOD, d[k]);
      idle(2);
      n = 0;
      repeat (2 * MOD_PHASES) begin
        @(posedge sys_clk);
        #1;
        if (clkRun === 1'b0) n++;
      end
      check64(64'(n), 64'(exp[k]));
    end
    wr(ADDR_CLK_MOD, 64'h0);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_pkg();
    t_status();
    t_readout();
    t_core_events();
    t_thresh();
    t_crit_lock();
    t_regs();
    t_unmapped();
    t_modulation();
    test_done();
  end
endmodule
`default_nettype wire
